// ===== inc/cssr_pkg.sv
// Constants and shared types for the card slot status and counter registers
// Notes on behaviour
// - Page 10 on Register1 reads and writes the counter high byte, reset A4h.
// - Page 11 on Register1 reads and writes the counter low byte, reset 74h.
// - One shared 16-bit counter copy serves every slot, whatever address wrote it.
// - Slots 3, 4, 5 each own Slot_status_control: read gives status, write sets control.
// - Status bit 7 shows whether the slot's card is active.
// - Bit 6 sets when the card answers too early during answer-to-reset.
// - Bit 5 sets when the card gives no answer within the allowed time.
// - Bit 4 sets on overcurrent or overheating during a card session.
// - Bit 3 sets whenever the voltage supervisor reports a supply fault.
// - Fault flags are sticky and clear only when the host reads the status byte.
// - Bit 2 follows power-down clock switching to half the internal oscillator.
// - Bit 0 gives the live presence pin level; bit 1 is reserved.
// - Interrupt output is low while any fault flag is set, released after read.
// - Supply flag comes up set after power-on; interrupt low while supervisor active.
// - Host picks Register1 page: 10 high byte, 11 low byte.
// - Page 01 on Register1 reaches the shared first delay count, reset AAh.
// - Start accepted only with no supply/overload fault and card present; 0 deactivates.
package cssr_pkg;

  localparam int unsigned NUM_SLOTS = 3;
  localparam int unsigned PAGE_W = 2;

  localparam logic [7:0] ADDR_SLOT1 = 8'h01;
  localparam logic [7:0] ADDR_SLOT2 = 8'h02;
  localparam logic [7:0] ADDR_SLOT3 = 8'h03;

  localparam logic [7:0] FIRST_DELAY_RST = 8'hAA;
  localparam logic [7:0] COUNT_HIGH_RST = 8'hA4;
  localparam logic [7:0] COUNT_LOW_RST = 8'h74;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Status byte layout
  localparam int unsigned STS_ACTIVE_BIT = 7;
  localparam int unsigned STS_EARLY_BIT = 6;
  localparam int unsigned STS_MUTE_BIT = 5;
  localparam int unsigned STS_OVERLOAD_BIT = 4;
  localparam int unsigned STS_SUPPLY_BIT = 3;
  localparam int unsigned STS_CLOCK_SWITCHED_FLAG_BIT = 2;
  localparam int unsigned STS_PRESENCE_BIT = 0;

  // Control byte layout
  localparam int unsigned CTL_LOW_VOLT_BIT = 7;
  localparam int unsigned CTL_IO_CONNECT_BIT = 6;
  localparam int unsigned CTL_PAGE_LSB = 4;
  localparam int unsigned CTL_POWER_REDUCE_BIT = 3;
  localparam int unsigned CTL_VOLT_HIGH_BIT = 2;
  localparam int unsigned CTL_WARM_BIT = 1;
  localparam int unsigned CTL_START_BIT = 0;

  typedef enum logic [PAGE_W-1:0] {
    PAGE_CLK_CTRL = 2'h0,
    PAGE_FIRST_DELAY = 2'h1,
    PAGE_COUNT_HIGH = 2'h2,
    PAGE_COUNT_LOW = 2'h3
  } cssr_page_t;

  typedef struct packed {
    logic early;
    logic mute;
    logic overload;
    logic supply;
  } cssr_flags_t;

endpackage : cssr_pkg

// ===== core/cssr_count_regs.sv
// Shared answer window counter and first delay count bytes
`timescale 1ns/100ps
module cssr_count_regs (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_wr_first,
  input wire logic i_wr_high,
  input wire logic i_wr_low,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_first_delay_count,
  output logic [7:0] o_count_high,
  output logic [7:0] o_count_low
);

  typedef struct packed {
    logic [7:0] first;
    logic [7:0] high;
    logic [7:0] low;
  } cssr_count_state_t;

  cssr_count_state_t state_q;
  cssr_count_state_t state_d;

  always_comb begin
    state_d = state_q;
    if (i_wr_first) begin
      state_d.first = i_wdata;
    end
    if (i_wr_high) begin
      state_d.high = i_wdata;
    end
    if (i_wr_low) begin
      state_d.low = i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= '{first: cssr_pkg::FIRST_DELAY_RST, high: cssr_pkg::COUNT_HIGH_RST, low: cssr_pkg::COUNT_LOW_RST};
    end else begin
      state_q <= state_d;
    end
  end

  assign o_first_delay_count = state_q.first;
  assign o_count_high = state_q.high;
  assign o_count_low = state_q.low;

endmodule : cssr_count_regs

// ===== core/cssr_slot_ctrl.sv
// Write side control byte of one card slot
`timescale 1ns/100ps
module cssr_slot_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_supply_fault_flag,
  input wire logic i_overload_fault_flag,
  input wire logic i_presence_pin_level,
  input wire logic i_mute_event,
  output logic [7:0] o_ctrl
);

  typedef struct packed {
    logic [7:0] ctrl;
  } cssr_ctrl_state_t;

  cssr_ctrl_state_t state_q;
  cssr_ctrl_state_t state_d;

  always_comb begin
    state_d = state_q;
    if (i_wr) begin
      state_d.ctrl[cssr_pkg::CTL_IO_CONNECT_BIT] = i_wdata[cssr_pkg::CTL_IO_CONNECT_BIT];
      state_d.ctrl[cssr_pkg::CTL_PAGE_LSB +: cssr_pkg::PAGE_W] = i_wdata[cssr_pkg::CTL_PAGE_LSB +: cssr_pkg::PAGE_W];
      state_d.ctrl[cssr_pkg::CTL_POWER_REDUCE_BIT] = i_wdata[cssr_pkg::CTL_POWER_REDUCE_BIT];
      // Supply voltage must not change under a running card
      if (!state_q.ctrl[cssr_pkg::CTL_START_BIT]) begin
        state_d.ctrl[cssr_pkg::CTL_LOW_VOLT_BIT] = i_wdata[cssr_pkg::CTL_LOW_VOLT_BIT];
        state_d.ctrl[cssr_pkg::CTL_VOLT_HIGH_BIT] = i_wdata[cssr_pkg::CTL_VOLT_HIGH_BIT];
      end
      if (i_wdata[cssr_pkg::CTL_WARM_BIT]) begin
        state_d.ctrl[cssr_pkg::CTL_WARM_BIT] = 1'b1;
      end
      // start gated by faults and presence
      if (!i_wdata[cssr_pkg::CTL_START_BIT]) begin
        state_d.ctrl[cssr_pkg::CTL_START_BIT] = 1'b0;
      end else if (!i_supply_fault_flag && !i_overload_fault_flag && i_presence_pin_level) begin
        state_d.ctrl[cssr_pkg::CTL_START_BIT] = 1'b1;
        state_d.ctrl[cssr_pkg::CTL_WARM_BIT] = 1'b0;
      end
    end
    // Warm reset request ends when the card stays mute
    if (i_mute_event) begin
      state_d.ctrl[cssr_pkg::CTL_WARM_BIT] = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= '{ctrl: cssr_pkg::CTRL_RST};
    end else begin
      state_q <= state_d;
    end
  end

  assign o_ctrl = state_q.ctrl;

endmodule : cssr_slot_ctrl

// ===== core/cssr_card_slot_status_regs.sv
// Card slot 3 to 5 status/control registers and shared answer counter access
`timescale 1ns/100ps
module cssr_card_slot_status_regs (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Byte register access, one access per strobe
  input wire logic i_acc_wr,
  input wire logic i_acc_rd,
  input wire logic i_acc_reg1,
  input wire logic [7:0] i_acc_addr,
  input wire logic [7:0] i_acc_wdata,
  output logic [7:0] o_acc_rdata,
  output logic o_acc_rvalid,
  // Page fields of slots 1 and 2, held elsewhere in the device
  input wire logic [1:0] i_page_sel_s1,
  input wire logic [1:0] i_page_sel_s2,
  // Per slot state from the sequencers, index 0 is slot 3
  input wire logic [2:0] i_card_active,
  input wire logic [2:0] i_atr_phase,
  input wire logic [2:0] i_answer_early,
  input wire logic [2:0] i_answer_mute,
  input wire logic [2:0] i_overload,
  input wire logic [2:0] i_clk_on_osc,
  input wire logic [2:0] i_presence_pin_level,
  // Supervisor
  input wire logic i_supply_fault,
  input wire logic i_supervisor_active,
  // Control outputs
  output logic [2:0] o_start,
  output logic [2:0] o_warm,
  output logic [2:0] o_low_voltage_select,
  output logic [2:0] o_voltage_high_select,
  output logic [2:0] o_io_connect,
  output logic [2:0] o_power_reduce,
  output logic [15:0] o_answer_window_count,
  output logic [7:0] o_first_delay_count,
  output logic o_interrupt_out_n
);

  localparam int unsigned N = cssr_pkg::NUM_SLOTS;

  typedef struct packed {
    cssr_pkg::cssr_flags_t [N-1:0] flags;
    logic [7:0] rdata;
    logic rvalid;
    logic irq_n;
  } cssr_main_state_t;

  cssr_main_state_t state_q;
  cssr_main_state_t state_d;

  logic [N-1:0] sel_slot;
  logic sel_s1;
  logic sel_s2;
  logic [N-1:0][7:0] ctrl;
  logic [N-1:0][7:0] status;
  logic [N-1:0] rd_clr;
  logic [N-1:0] wr_ctrl;
  cssr_pkg::cssr_page_t acc_page;
  logic r1_hit;
  logic r0_hit;
  logic [7:0] r0_data;
  logic wr_first;
  logic wr_high;
  logic wr_low;
  logic [7:0] count_high;
  logic [7:0] count_low;
  logic [7:0] first_delay;

  assign sel_s1 = (i_acc_addr == cssr_pkg::ADDR_SLOT1);
  assign sel_s2 = (i_acc_addr == cssr_pkg::ADDR_SLOT2);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_slot
      localparam logic [7:0] SLOT_ADDR = 8'(cssr_pkg::ADDR_SLOT3 + g);

      assign sel_slot[g] = (i_acc_addr == SLOT_ADDR);
      assign wr_ctrl[g] = i_acc_wr && !i_acc_reg1 && sel_slot[g];
      // clear side effect of a status read
      assign rd_clr[g] = i_acc_rd && !i_acc_reg1 && sel_slot[g];

      cssr_slot_ctrl u_ctrl (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_wr(wr_ctrl[g]),
        .i_wdata(i_acc_wdata),
        .i_supply_fault_flag(state_q.flags[g].supply),
        .i_overload_fault_flag(state_q.flags[g].overload),
        .i_presence_pin_level(i_presence_pin_level[g]),
        .i_mute_event(i_answer_mute[g] && i_atr_phase[g]),
        .o_ctrl(ctrl[g])
      );

      always_comb begin
        status[g] = cssr_pkg::READ_ZERO;
        status[g][cssr_pkg::STS_ACTIVE_BIT] = i_card_active[g];
        status[g][cssr_pkg::STS_EARLY_BIT] = state_q.flags[g].early;
        status[g][cssr_pkg::STS_MUTE_BIT] = state_q.flags[g].mute;
        status[g][cssr_pkg::STS_OVERLOAD_BIT] = state_q.flags[g].overload;
        status[g][cssr_pkg::STS_SUPPLY_BIT] = state_q.flags[g].supply;
        status[g][cssr_pkg::STS_CLOCK_SWITCHED_FLAG_BIT] = i_clk_on_osc[g];
        status[g][cssr_pkg::STS_PRESENCE_BIT] = i_presence_pin_level[g];
      end

      assign o_start[g] = ctrl[g][cssr_pkg::CTL_START_BIT];
      assign o_warm[g] = ctrl[g][cssr_pkg::CTL_WARM_BIT];
      assign o_low_voltage_select[g] = ctrl[g][cssr_pkg::CTL_LOW_VOLT_BIT];
      assign o_voltage_high_select[g] = ctrl[g][cssr_pkg::CTL_VOLT_HIGH_BIT];
      assign o_io_connect[g] = ctrl[g][cssr_pkg::CTL_IO_CONNECT_BIT];
      assign o_power_reduce[g] = ctrl[g][cssr_pkg::CTL_POWER_REDUCE_BIT];
    end
  endgenerate

  // page taken from the addressed slot
  always_comb begin
    acc_page = cssr_pkg::PAGE_CLK_CTRL;
    r1_hit = 1'b0;
    if (sel_s1) begin
      acc_page = cssr_pkg::cssr_page_t'(i_page_sel_s1);
      r1_hit = 1'b1;
    end else if (sel_s2) begin
      acc_page = cssr_pkg::cssr_page_t'(i_page_sel_s2);
      r1_hit = 1'b1;
    end else begin
      for (int k = 0; k < N; k++) begin
        if (sel_slot[k]) begin
          acc_page = cssr_pkg::cssr_page_t'(ctrl[k][cssr_pkg::CTL_PAGE_LSB +: cssr_pkg::PAGE_W]);
          r1_hit = 1'b1;
        end
      end
    end
  end

  // any slot address reaches the single copy
  assign wr_first = i_acc_wr && i_acc_reg1 && r1_hit && (acc_page == cssr_pkg::PAGE_FIRST_DELAY);
  assign wr_high = i_acc_wr && i_acc_reg1 && r1_hit && (acc_page == cssr_pkg::PAGE_COUNT_HIGH);
  assign wr_low = i_acc_wr && i_acc_reg1 && r1_hit && (acc_page == cssr_pkg::PAGE_COUNT_LOW);

  cssr_count_regs u_count (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_wr_first(wr_first),
    .i_wr_high(wr_high),
    .i_wr_low(wr_low),
    .i_wdata(i_acc_wdata),
    .o_first_delay_count(first_delay),
    .o_count_high(count_high),
    .o_count_low(count_low)
  );

  // Status of the addressed slot, zero elsewhere
  always_comb begin
    r0_data = cssr_pkg::READ_ZERO;
    r0_hit = 1'b0;
    for (int k = 0; k < N; k++) begin
      if (sel_slot[k]) begin
        r0_data = status[k];
        r0_hit = 1'b1;
      end
    end
  end

  always_comb begin
    logic any_flag;
    any_flag = 1'b0;
    state_d = state_q;
    state_d.rvalid = i_acc_rd;
    for (int k = 0; k < N; k++) begin
      // event beats a same cycle read clear
      state_d.flags[k].early = (i_answer_early[k] && i_atr_phase[k]) || (state_q.flags[k].early && !rd_clr[k]);
      state_d.flags[k].mute = (i_answer_mute[k] && i_atr_phase[k]) || (state_q.flags[k].mute && !rd_clr[k]);
      // overload only counts in a session
      state_d.flags[k].overload = (i_overload[k] && i_card_active[k]) || (state_q.flags[k].overload && !rd_clr[k]);
      state_d.flags[k].supply = i_supply_fault || (state_q.flags[k].supply && !rd_clr[k]);
      any_flag = any_flag || (|state_d.flags[k]);
    end
    // held low while supervisor still active
    state_d.irq_n = !(any_flag || i_supervisor_active);
    if (i_acc_rd) begin
      if (!i_acc_reg1) begin
        // status read at the slot address
        state_d.rdata = r0_hit ? r0_data : cssr_pkg::READ_ZERO;
      end else if (r1_hit) begin
        case (acc_page)
          cssr_pkg::PAGE_FIRST_DELAY: state_d.rdata = first_delay;
          cssr_pkg::PAGE_COUNT_HIGH: state_d.rdata = count_high;
          cssr_pkg::PAGE_COUNT_LOW: state_d.rdata = count_low;
          default: state_d.rdata = cssr_pkg::READ_ZERO;
        endcase
      end else begin
        state_d.rdata = cssr_pkg::READ_ZERO;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int k = 0; k < N; k++) begin
        state_q.flags[k] <= '{early: 1'b0, mute: 1'b0, overload: 1'b0, supply: 1'b1};
      end
      state_q.rdata <= cssr_pkg::READ_ZERO;
      state_q.rvalid <= 1'b0;
      state_q.irq_n <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_acc_rdata = state_q.rdata;
  assign o_acc_rvalid = state_q.rvalid;
  assign o_interrupt_out_n = state_q.irq_n;
  assign o_answer_window_count = {count_high, count_low};
  assign o_first_delay_count = first_delay;

endmodule : cssr_card_slot_status_regs

// ===== tb/cssr_host_model.sv
// Host model driving byte register accesses and the page fields
`timescale 1ns/100ps
module cssr_host_model (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_acc_rdata,
  input wire logic i_acc_rvalid,
  output logic o_acc_wr,
  output logic o_acc_rd,
  output logic o_acc_reg1,
  output logic [7:0] o_acc_addr,
  output logic [7:0] o_acc_wdata,
  output logic [1:0] o_page_sel_s1,
  output logic [1:0] o_page_sel_s2
);
  initial begin
    o_acc_wr = 1'b0;
    o_acc_rd = 1'b0;
    o_acc_reg1 = 1'b0;
    o_acc_addr = 8'h00;
    o_acc_wdata = 8'h00;
    o_page_sel_s1 = 2'h0;
    o_page_sel_s2 = 2'h0;
  end
  task automatic pages(input logic [1:0] a, input logic [1:0] b);
    @(posedge i_clk_sys);
    #1;
    o_page_sel_s1 = a;
    o_page_sel_s2 = b;
  endtask : pages
  // Released bus shows inverted values, never the last ones
  task automatic idle();
    o_acc_reg1 = ~o_acc_reg1;
    o_acc_addr = ~o_acc_addr;
    o_acc_wdata = ~o_acc_wdata;
  endtask : idle
  task automatic wr(input logic r1, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    #1;
    o_acc_wr = 1'b1;
    o_acc_reg1 = r1;
    o_acc_addr = a;
    o_acc_wdata = d;
    @(posedge i_clk_sys);
    #1;
    o_acc_wr = 1'b0;
    idle();
  endtask : wr
  task automatic rd(input logic r1, input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    #1;
    o_acc_rd = 1'b1;
    o_acc_reg1 = r1;
    o_acc_addr = a;
    @(posedge i_clk_sys);
    #1;
    o_acc_rd = 1'b0;
    idle();
    d = (i_acc_rvalid === 1'b1) ? i_acc_rdata : 8'hXX;
  endtask : rd
endmodule : cssr_host_model

// ===== tb/cssr_card_slot_status_regs_assertions.sv
// Port checks of the card slot status registers
`timescale 1ns/100ps
module cssr_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_acc_wr,
  input wire logic i_acc_rd,
  input wire logic i_acc_reg1,
  input wire logic [7:0] i_acc_addr,
  input wire logic [7:0] i_acc_wdata,
  input wire logic [7:0] o_acc_rdata,
  input wire logic o_acc_rvalid,
  input wire logic [1:0] i_page_sel_s1,
  input wire logic [1:0] i_page_sel_s2,
  input wire logic [2:0] i_card_active,
  input wire logic [2:0] i_clk_on_osc,
  input wire logic [2:0] i_presence_pin_level,
  input wire logic i_supply_fault,
  input wire logic i_supervisor_active,
  input wire logic [2:0] o_start,
  input wire logic [15:0] o_answer_window_count,
  input wire logic [7:0] o_first_delay_count,
  input wire logic o_interrupt_out_n
);
  default clocking dc @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_r1_wr(logic [1:0] pg);
    i_acc_wr && i_acc_reg1 && (i_acc_addr == 8'h01 && i_page_sel_s1 == pg ||
      i_acc_addr == 8'h02 && i_page_sel_s2 == pg);
  endsequence
  sequence s_sts_rd;
    i_acc_rd && !i_acc_reg1 && i_acc_addr == 8'h03;
  endsequence
  sequence s_ctl_wr(logic v);
    i_acc_wr && !i_acc_reg1 && i_acc_addr == 8'h03 && i_acc_wdata[0] == v;
  endsequence
  a_read_answers: assert property (i_acc_rd |=> o_acc_rvalid)
    else $error("read not answered");
  a_rvalid_quiet: assert property (!i_acc_rd |=> !o_acc_rvalid)
    else $error("rvalid without read");
  a_count_high_wr: assert property (s_r1_wr(2'h2) |=> o_answer_window_count[15:8] == $past(i_acc_wdata))
    else $error("counter high byte not written");
  a_count_low_wr: assert property (s_r1_wr(2'h3) |=> o_answer_window_count[7:0] == $past(i_acc_wdata))
    else $error("counter low byte not written");
  a_first_delay_wr: assert property (s_r1_wr(2'h1) |=> o_first_delay_count == $past(i_acc_wdata))
    else $error("first delay not written");
  a_active_bit: assert property (s_sts_rd |=> o_acc_rdata[7] == $past(i_card_active[0]))
    else $error("active bit wrong");
  a_status_low_bits: assert property (s_sts_rd |=>
    o_acc_rdata[2:0] == {$past(i_clk_on_osc[0]), 1'b0, $past(i_presence_pin_level[0])})
    else $error("status low bits wrong");
  a_supply_irq: assert property (i_supply_fault |-> ##[1:2] !o_interrupt_out_n)
    else $error("supply fault not signalled");
  a_supervisor_irq: assert property (i_supervisor_active |-> ##[1:2] !o_interrupt_out_n)
    else $error("interrupt released under supervisor");
  a_start_refused: assert property ((s_ctl_wr(1'b1) ##0 (!i_presence_pin_level[0] && !o_start[0]))
    |=> !o_start[0])
    else $error("start taken without card");
  a_stop_clears: assert property (s_ctl_wr(1'b0) |=> !o_start[0])
    else $error("stop write ignored");
endmodule : cssr_checker
bind cssr_card_slot_status_regs cssr_checker u_chk (.i_clk_sys, .i_rst_b, .i_acc_wr, .i_acc_rd, .i_acc_reg1,
  .i_acc_addr, .i_acc_wdata, .o_acc_rdata, .o_acc_rvalid, .i_page_sel_s1, .i_page_sel_s2, .i_card_active,
  .i_clk_on_osc, .i_presence_pin_level, .i_supply_fault, .i_supervisor_active, .o_start,
  .o_answer_window_count, .o_first_delay_count, .o_interrupt_out_n);

// ===== tb/cssr_card_slot_status_regs_tb_top.sv
// Self-checking bench for the card slot status registers
`timescale 1ns/100ps
module cssr_card_slot_status_regs_tb_top;
  logic i_clk_sys, i_rst_b, i_acc_wr, i_acc_rd, i_acc_reg1, o_acc_rvalid, o_interrupt_out_n;
  logic i_supply_fault, i_supervisor_active;
  logic [7:0] i_acc_addr, i_acc_wdata, o_acc_rdata, o_first_delay_count;
  logic [1:0] i_page_sel_s1, i_page_sel_s2;
  logic [2:0] i_card_active, i_atr_phase, i_answer_early, i_answer_mute, i_overload, i_clk_on_osc;
  logic [2:0] i_presence_pin_level, o_start, o_low_voltage_select, o_voltage_high_select;
  logic [2:0] o_io_connect, o_power_reduce, o_warm;
  logic [15:0] o_answer_window_count;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  cssr_card_slot_status_regs dut (.i_clk_sys, .i_rst_b, .i_acc_wr, .i_acc_rd, .i_acc_reg1, .i_acc_addr,
    .i_acc_wdata, .o_acc_rdata, .o_acc_rvalid, .i_page_sel_s1, .i_page_sel_s2, .i_card_active, .i_atr_phase,
    .i_answer_early, .i_answer_mute, .i_overload, .i_clk_on_osc, .i_presence_pin_level, .i_supply_fault,
    .i_supervisor_active, .o_start, .o_warm, .o_low_voltage_select, .o_voltage_high_select, .o_io_connect,
    .o_power_reduce, .o_answer_window_count, .o_first_delay_count, .o_interrupt_out_n);
  cssr_host_model host (.i_clk_sys, .i_acc_rdata(o_acc_rdata), .i_acc_rvalid(o_acc_rvalid),
    .o_acc_wr(i_acc_wr), .o_acc_rd(i_acc_rd), .o_acc_reg1(i_acc_reg1), .o_acc_addr(i_acc_addr),
    .o_acc_wdata(i_acc_wdata), .o_page_sel_s1(i_page_sel_s1), .o_page_sel_s2(i_page_sel_s2));
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rchk(input string nm, input logic r1, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(r1, a, d);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask : rchk
  task automatic tick();
    @(posedge i_clk_sys);
    #1;
  endtask : tick
  task automatic t_por();
    chk("count", 16'hA474, o_answer_window_count);
    chk("first", 16'h00AA, {8'h00, o_first_delay_count});
    host.pages(2'h2, 2'h3);
    rchk("high", 1'b1, 8'h01, 8'hA4);
    rchk("low", 1'b1, 8'h02, 8'h74);
    host.pages(2'h1, 2'h0);
    rchk("first rd", 1'b1, 8'h01, 8'hAA);
    rchk("page0", 1'b1, 8'h02, 8'h00);
    rchk("slot1 r0", 1'b0, 8'h01, 8'h00);
    rchk("unmapped", 1'b0, 8'h06, 8'h00);
    rchk("sts3", 1'b0, 8'h03, 8'h89);
    rchk("sts4", 1'b0, 8'h04, 8'h8C);
    rchk("sts5", 1'b0, 8'h05, 8'h09);
    tick();
    chk("irq sup", 16'h0000, {15'h0, o_interrupt_out_n});
    i_supervisor_active = 1'b0;
    tick();
    tick();
    chk("irq free", 16'h0001, {15'h0, o_interrupt_out_n});
    rchk("sts3 again", 1'b0, 8'h03, 8'h81);
  endtask : t_por
  task automatic t_counts();
    host.pages(2'h3, 2'h2);
    host.wr(1'b1, 8'h02, 8'h5A);
    host.wr(1'b1, 8'h01, 8'hC3);
    chk("count", 16'h5AC3, o_answer_window_count);
    host.pages(2'h2, 2'h3);
    rchk("high", 1'b1, 8'h01, 8'h5A);
    rchk("low", 1'b1, 8'h02, 8'hC3);
    host.pages(2'h1, 2'h1);
    host.wr(1'b1, 8'h02, 8'h3C);
    chk("first", 16'h003C, {8'h00, o_first_delay_count});
  endtask : t_counts
  task automatic t_flags();
    // Early answer outside the answer phase must leave no trace
    tick();
    i_answer_early[1] = 1'b1;
    tick();
    i_answer_early[1] = 1'b0;
    rchk("no early", 1'b0, 8'h04, 8'h84);
    i_atr_phase[1] = 1'b1;
    for (int k = 0; k < 3; k++) begin
      tick();
      {i_answer_early[1], i_answer_mute[1], i_overload[1]} = 3'b100 >> k;
      tick();
      {i_answer_early[1], i_answer_mute[1], i_overload[1]} = 3'b000;
      repeat (3) tick();
      chk("irq set", 16'h0000, {15'h0, o_interrupt_out_n});
      rchk("flag", 1'b0, 8'h04, 8'h84 | (8'h40 >> k));
      tick();
      chk("irq clr", 16'h0001, {15'h0, o_interrupt_out_n});
      rchk("flag clr", 1'b0, 8'h04, 8'h84);
    end
    tick();
    i_supply_fault = 1'b1;
    tick();
    i_supply_fault = 1'b0;
    host.wr(1'b0, 8'h05, 8'h01);
    chk("start5 no", 16'h0000, {15'h0, o_start[2]});
    rchk("sup3", 1'b0, 8'h03, 8'h89);
    rchk("sup4", 1'b0, 8'h04, 8'h8C);
    rchk("sup5", 1'b0, 8'h05, 8'h09);
    tick();
    chk("irq sup", 16'h0001, {15'h0, o_interrupt_out_n});
    host.wr(1'b0, 8'h05, 8'h01);
    chk("start5", 16'h0001, {15'h0, o_start[2]});
  endtask : t_flags
  task automatic t_start();
    tick();
    i_presence_pin_level[0] = 1'b0;
    host.wr(1'b0, 8'h03, 8'h01);
    chk("start3 no", 16'h0000, {15'h0, o_start[0]});
    i_presence_pin_level[0] = 1'b1;
    host.wr(1'b0, 8'h03, 8'h01);
    chk("start3", 16'h0001, {15'h0, o_start[0]});
    host.wr(1'b0, 8'h03, 8'h00);
    chk("stop3", 16'h0000, {15'h0, o_start[0]});
    host.wr(1'b0, 8'h04, 8'hCC);
    chk("ctl4", 16'h000F, {12'h0, o_low_voltage_select[1], o_io_connect[1], o_power_reduce[1],
      o_voltage_high_select[1]});
    // Own page bits of slot 4 reach the shared counter
    host.wr(1'b0, 8'h04, 8'hEE);
    chk("warm4", 16'h0001, {15'h0, o_warm[1]});
    host.wr(1'b1, 8'h04, 8'h96);
    chk("count4", 16'h96C3, o_answer_window_count);
    rchk("high4", 1'b1, 8'h04, 8'h96);
    tick();
    i_answer_mute[1] = 1'b1;
    tick();
    i_answer_mute[1] = 1'b0;
    chk("warm4 clr", 16'h0000, {15'h0, o_warm[1]});
  endtask : t_start
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    i_rst_b = 1'b0;
    i_card_active = 3'b011;
    i_atr_phase = 3'b000;
    i_answer_early = 3'b000;
    i_answer_mute = 3'b000;
    i_overload = 3'b000;
    i_clk_on_osc = 3'b010;
    i_presence_pin_level = 3'b101;
    i_supply_fault = 1'b0;
    i_supervisor_active = 1'b1;
    repeat (8) @(posedge i_clk_sys);
    #1;
    i_rst_b = 1'b1;
    t_por();
    t_counts();
    t_flags();
    t_start();
    summarize();
  end
endmodule : cssr_card_slot_status_regs_tb_top
